// ---- design/tlps_pkg.sv ----
package tlps_pkg;
  // stream and register widths
  localparam int RAW_W = 16;
  localparam int PIX_W = 14;
  localparam int DW    = 32;
  localparam int AW    = 4;

  // feature register indices
  localparam logic [AW-1:0] IDX_LIN_EN  = 4'h0;
  localparam logic [AW-1:0] IDX_STEP    = 4'h1;
  localparam logic [AW-1:0] IDX_GAIN    = 4'h2;
  localparam logic [AW-1:0] IDX_EXP     = 4'h3;
  localparam logic [AW-1:0] IDX_SHIFT   = 4'h4;
  localparam logic [AW-1:0] IDX_POS_OFS = 4'h5;
  localparam logic [AW-1:0] IDX_SOFS    = 4'h6;
  localparam logic [AW-1:0] IDX_SAVE    = 4'h7;
  localparam logic [AW-1:0] IDX_REFL    = 4'h8;
  localparam logic [AW-1:0] IDX_EMIS    = 4'h9;
  localparam logic [AW-1:0] IDX_PANE_TR = 4'hA;
  localparam logic [AW-1:0] IDX_PANE_T  = 4'hB;
  localparam logic [AW-1:0] IDX_AIR_TR  = 4'hC;
  localparam logic [AW-1:0] IDX_AIR_T   = 4'hD;
  localparam logic [AW-1:0] IDX_STATUS  = 4'hE;

  // fixed-point unity (q16) and step sizes in millikelvin
  localparam logic [DW-1:0] ONE_Q16    = 32'h0001_0000;
  localparam int            Q_FRAC     = 16;
  localparam int            STEP_HI_MK = 40;
  localparam int            STEP_LO_MK = 400;
  localparam int            STEP_RATIO = STEP_LO_MK / STEP_HI_MK;
  // divide by ten as multiply by 0xCCCD and shift by 19
  localparam logic [15:0]   DIV10_MUL  = 16'hCCCD;
  localparam int            DIV10_SH   = 19;
  localparam logic [PIX_W-1:0] PIX_MAX = 14'h3FFF;
  localparam logic [DW-1:0] SIGN_MASK  = 32'h7FFF_FFFF;

  typedef struct packed {
    logic             sof;
    logic [RAW_W-1:0] sig;
  } tlps_pix_in_t;

  typedef struct packed {
    logic             sof;
    logic [PIX_W-1:0] data;
  } tlps_pix_out_t;

  typedef struct packed {
    logic [DW-1:0] gain;
    logic [DW-1:0] expo;
    logic [DW-1:0] shift;
    logic [DW-1:0] pos_ofs;
    logic [DW-1:0] sofs;
  } tlps_conv_t;

  typedef struct packed {
    logic          lin_en;
    logic          step;
    tlps_conv_t    bank_hi;
    tlps_conv_t    bank_lo;
    logic [DW-1:0] refl;
    logic [DW-1:0] emis;
    logic [DW-1:0] pane_tr;
    logic [DW-1:0] pane_t;
    logic [DW-1:0] air_tr;
    logic [DW-1:0] air_t;
  } tlps_settings_t;

  typedef enum logic [0:0] {
    TLPS_BOOT = 1'b0,
    TLPS_RUN  = 1'b1
  } tlps_state_t;
endpackage

// ---- design/tlps_buf2.sv ----
`timescale 1ns/10ps
module tlps_buf2 import tlps_pkg::*; #(
  parameter int W = 15
) (
  input  wire logic         clk_i,      // system clock
  input  wire logic         rst_n_i,    // synchronised reset
  input  wire logic         in_valid_i, // word offered
  output logic              in_ready_o, // room for a word
  input  wire logic [W-1:0] in_data_i,  // offered word
  output logic              out_valid_o,// word available
  input  wire logic         out_ready_i,// receiver takes word
  output logic [W-1:0]      out_data_o  // oldest word
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  // two entries so a receiver stall costs no word
  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage has no reset; only the pointers matter
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RL14
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("buffered word changed while stalled");
  a_buf_full: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RL14
    count == 2'h2 && !out_ready_i |=> !in_ready_o)
    else $error("buffer accepted while full");
endmodule

// ---- design/tlps_scaler.sv ----
// What this block does
// RL1 - offers video as 14-bit pixels linear in scene temperature
// RL2 - linear enable set to 1 turns linear output on, 0 off
// RL3 - step select 0 gives 0.4 K per count, 1 gives 0.04 K
// RL4 - in linear mode pixel times selected step equals kelvin
// RL5 - raw mode exposes a separate constant set for each gain mode
// RL6 - gain integer, exponent and shift float, positive float offset, signed int offset
// RL7 - a gain mode change loads that mode's constants automatically
// RL8 - host may write the signed offset for one-point calibration
// RL9 - save command stores all settings as power-on defaults
// RL10 - scene correction acts only while linear output is on
// RL11 - emissivity and cover pane transmittance default to 1.0
// RL12 - holds background, pane, air inputs and applies them in linear mode
// RL13 - default scene parameters leave the signal unchanged
// RL14 - one pixel out per pixel in, order kept, modes change at frames
`timescale 1ns/10ps
module tlps_scaler import tlps_pkg::*; (
  input  wire logic           sys_clk_i,   // 100 MHz clock
  input  wire logic           rst_n_i,     // async reset, active low
  input  wire logic           gain_hi_i,   // detector in high gain mode
  input  wire tlps_settings_t boot_set_i,  // stored power-on settings
  input  wire logic           reg_wr_i,    // feature write strobe
  input  wire logic           reg_rd_i,    // feature read strobe
  input  wire logic [AW-1:0]  reg_idx_i,   // feature register index
  input  wire logic [DW-1:0]  reg_wdata_i, // write data
  output logic [DW-1:0]       reg_rdata_o, // read data, next cycle
  output logic                save_we_o,   // store settings pulse
  output tlps_settings_t      save_set_o,  // settings to store
  input  wire logic           pix_valid_i, // raw pixel offered
  output logic                pix_ready_o, // raw pixel taken
  input  wire tlps_pix_in_t   pix_i,       // raw pixel and frame start
  output logic                vid_valid_o, // video pixel available
  input  wire logic           vid_ready_i, // receiver takes pixel
  output tlps_pix_out_t       vid_o        // video pixel
);
  logic           rst_q1;
  logic           rst_n;
  tlps_state_t    state;
  tlps_state_t    next_state;
  logic           lin_en;
  logic           step;
  tlps_conv_t     bank [2];
  tlps_conv_t     conv;
  logic           gain_q;
  logic [DW-1:0]  refl;
  logic [DW-1:0]  emis;
  logic [DW-1:0]  pane_tr;
  logic [DW-1:0]  pane_t;
  logic [DW-1:0]  air_tr;
  logic [DW-1:0]  air_t;
  logic           fr_lin;
  logic           fr_step;
  logic           cur_lin;
  logic           cur_step;
  logic           push;
  logic           buf_ready;
  tlps_pix_out_t  push_data;
  logic           run;
  logic           wr;

  // reset released through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // one boot cycle pulls in stored defaults, then run
  always_comb begin
    case (state)
      TLPS_BOOT: next_state = TLPS_RUN;
      TLPS_RUN:  next_state = TLPS_RUN;
      default:   next_state = TLPS_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= TLPS_BOOT;
    end else begin
      state <= next_state;
    end
  end

  assign run = (state == TLPS_RUN);
  assign wr  = reg_wr_i && run;

  // mode settings; stored defaults load after reset release
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lin_en <= 1'b0;
      step   <= 1'b0;
    end else if (!run) begin
      lin_en <= boot_set_i.lin_en;
      step   <= boot_set_i.step;
    end else if (wr && reg_idx_i == IDX_LIN_EN) begin
      lin_en <= reg_wdata_i[0]; // see RL2
    end else if (wr && reg_idx_i == IDX_STEP) begin
      step <= reg_wdata_i[0]; // see RL3
    end
  end

  // scene parameters; unity factors make every correction term zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      refl    <= '0;
      emis    <= ONE_Q16; // see RL11
      pane_tr <= ONE_Q16; // see RL11
      pane_t  <= '0;
      air_tr  <= ONE_Q16;
      air_t   <= '0;
    end else if (!run) begin
      refl    <= boot_set_i.refl;
      emis    <= boot_set_i.emis;
      pane_tr <= boot_set_i.pane_tr;
      pane_t  <= boot_set_i.pane_t;
      air_tr  <= boot_set_i.air_tr;
      air_t   <= boot_set_i.air_t;
    end else if (wr) begin
      case (reg_idx_i) // see RL12
        IDX_REFL:    refl    <= reg_wdata_i;
        IDX_EMIS:    emis    <= reg_wdata_i;
        IDX_PANE_TR: pane_tr <= reg_wdata_i;
        IDX_PANE_T:  pane_t  <= reg_wdata_i;
        IDX_AIR_TR:  air_tr  <= reg_wdata_i;
        IDX_AIR_T:   air_t   <= reg_wdata_i;
        default:     refl    <= refl;
      endcase
    end
  end

  // one constant set per gain mode; host writes land in the live mode's set
  function automatic tlps_conv_t conv_upd(input tlps_conv_t c, input logic [AW-1:0] idx,
                                          input logic [DW-1:0] d);
    tlps_conv_t r;
    r = c;
    case (idx) // see RL6
      IDX_GAIN:    r.gain    = d;
      IDX_EXP:     r.expo    = d;
      IDX_SHIFT:   r.shift   = d;
      IDX_POS_OFS: r.pos_ofs = d & SIGN_MASK; // float sign forced positive
      IDX_SOFS:    r.sofs    = d; // see RL8
      default:     r         = c;
    endcase
    return r;
  endfunction

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bank[0] <= '0;
      bank[1] <= '0;
    end else if (!run) begin
      bank[1] <= boot_set_i.bank_hi;
      bank[0] <= boot_set_i.bank_lo;
    end else if (wr) begin
      bank[gain_q] <= conv_upd(bank[gain_q], reg_idx_i, reg_wdata_i); // see RL5
    end
  end

  // live conversion set; reloaded whenever the gain mode flips
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gain_q <= 1'b0;
      conv   <= '0;
    end else if (!run) begin
      gain_q <= gain_hi_i;
      conv   <= gain_hi_i ? boot_set_i.bank_hi : boot_set_i.bank_lo;
    end else if (gain_hi_i != gain_q) begin
      gain_q <= gain_hi_i;
      conv   <= bank[gain_hi_i]; // see RL7
    end else if (wr) begin
      conv <= conv_upd(conv, reg_idx_i, reg_wdata_i); // see RL8
    end
  end

  // settings snapshot; the store keeps it as the next power-on values
  always_comb begin
    save_set_o         = '0;
    save_set_o.lin_en  = lin_en;
    save_set_o.step    = step;
    save_set_o.bank_hi = bank[1];
    save_set_o.bank_lo = bank[0];
    save_set_o.refl    = refl;
    save_set_o.emis    = emis;
    save_set_o.pane_tr = pane_tr;
    save_set_o.pane_t  = pane_t;
    save_set_o.air_tr  = air_tr;
    save_set_o.air_t   = air_t;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      save_we_o <= 1'b0;
    end else begin
      save_we_o <= wr && reg_idx_i == IDX_SAVE; // see RL9
    end
  end

  // registered read port
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_idx_i)
        IDX_LIN_EN:  reg_rdata_o <= {31'h0000_0000, lin_en};
        IDX_STEP:    reg_rdata_o <= {31'h0000_0000, step};
        IDX_GAIN:    reg_rdata_o <= conv.gain;
        IDX_EXP:     reg_rdata_o <= conv.expo;
        IDX_SHIFT:   reg_rdata_o <= conv.shift;
        IDX_POS_OFS: reg_rdata_o <= conv.pos_ofs;
        IDX_SOFS:    reg_rdata_o <= conv.sofs;
        IDX_REFL:    reg_rdata_o <= refl;
        IDX_EMIS:    reg_rdata_o <= emis;
        IDX_PANE_TR: reg_rdata_o <= pane_tr;
        IDX_PANE_T:  reg_rdata_o <= pane_t;
        IDX_AIR_TR:  reg_rdata_o <= air_tr;
        IDX_AIR_T:   reg_rdata_o <= air_t;
        IDX_STATUS:  reg_rdata_o <= {30'h0000_0000, gain_q, run};
        default:     reg_rdata_o <= '0;
      endcase
    end
  end

  // modes are taken at frame start so a frame never mixes formats
  assign cur_lin  = pix_i.sof ? lin_en : fr_lin;
  assign cur_step = pix_i.sof ? step : fr_step;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fr_lin  <= 1'b0;
      fr_step <= 1'b0;
    end else if (push && pix_i.sof) begin
      fr_lin  <= lin_en; // see RL14
      fr_step <= step;
    end
  end

  // one correction term: (1 - factor) * temperature, q16
  function automatic logic signed [33:0] corr_term(input logic [DW-1:0] f,
                                                   input logic [DW-1:0] t);
    logic signed [33:0] one_m;
    logic signed [67:0] p;
    one_m = $signed({2'b00, ONE_Q16}) - $signed({2'b00, f});
    p     = one_m * $signed({2'b00, t});
    return p[Q_FRAC +: 34];
  endfunction

  logic signed [35:0] corr_sig;
  logic signed [35:0] diff;
  logic signed [71:0] prod;
  logic signed [35:0] t_hi;
  logic        [17:0] t_clip;
  logic        [35:0] t_lo_w;
  logic [PIX_W-1:0]   lin_pix;

  // linear path: scene correction, offset, slope, then step scaling
  always_comb begin
    corr_sig = $signed({20'h00000, pix_i.sig}) // see RL10
             - 36'(corr_term(emis, refl)) // see RL12
             - 36'(corr_term(pane_tr, pane_t))
             - 36'(corr_term(air_tr, air_t)); // see RL13
    diff     = corr_sig - 36'($signed(conv.sofs));
    prod     = diff * $signed({4'h0, conv.gain});
    t_hi     = prod[Q_FRAC +: 36]; // counts of 0.04 K
    if (t_hi < 0) begin
      t_clip = '0;
    end else if (t_hi > 36'sh3_FFFF) begin
      t_clip = 18'h3FFFF;
    end else begin
      t_clip = t_hi[17:0];
    end
    t_lo_w = ({18'h00000, t_clip} * {20'h00000, DIV10_MUL}) >> DIV10_SH;
    if (cur_step) begin // see RL3
      lin_pix = (t_clip > {4'h0, PIX_MAX}) ? PIX_MAX : t_clip[PIX_W-1:0]; // see RL4
    end else begin
      lin_pix = (t_lo_w > {22'h0, PIX_MAX}) ? PIX_MAX : t_lo_w[PIX_W-1:0];
    end
  end

  // raw mode passes the low 14 bits of the detector signal untouched
  always_comb begin
    push_data.sof  = pix_i.sof;
    push_data.data = cur_lin ? lin_pix : pix_i.sig[PIX_W-1:0]; // see RL1
  end

  assign pix_ready_o = buf_ready && run;
  assign push        = pix_valid_i && pix_ready_o;

  tlps_buf2 #(
    .W ($bits(tlps_pix_out_t))
  ) u_buf (
    .clk_i       (sys_clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (pix_valid_i && run),
    .in_ready_o  (buf_ready),
    .in_data_i   (push_data),
    .out_valid_o (vid_valid_o),
    .out_ready_i (vid_ready_i),
    .out_data_o  (vid_o)
  );

  a_raw_passthru: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL2
    push && !cur_lin |-> push_data.data == pix_i.sig[PIX_W-1:0])
    else $error("raw pixel altered with linear off");
  a_gain_reload: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL7
    run && gain_hi_i != gain_q |=> conv == $past(bank[gain_hi_i]) && gain_q == $past(gain_hi_i))
    else $error("gain change did not load its constant set");
  a_sofs_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL8
    wr && reg_idx_i == IDX_SOFS && gain_hi_i == gain_q |=> conv.sofs == $past(reg_wdata_i))
    else $error("signed offset write lost");
  a_save_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL9
    wr && reg_idx_i == IDX_SAVE
      |=> save_we_o ##1 (!save_we_o || $past(wr && reg_idx_i == IDX_SAVE)))
    else $error("save command gave no store pulse");
  a_step_ratio: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL3
    push && cur_lin && !cur_step && t_clip < 18'h02710
      |-> lin_pix == 14'(t_clip / STEP_RATIO))
    else $error("low step count not one tenth of high");
  a_default_id: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL13
    emis == ONE_Q16 && pane_tr == ONE_Q16 && air_tr == ONE_Q16
      |-> corr_sig == $signed({20'h00000, pix_i.sig}))
    else $error("unity scene parameters changed the signal");
  a_frame_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL14
    !(push && pix_i.sof) |=> $stable(fr_lin) && $stable(fr_step))
    else $error("mode changed inside a frame");
  a_pos_float: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // see RL6
    run |-> !conv.pos_ofs[DW-1])
    else $error("positive offset holds a negative float");
endmodule

// ---- tb/tlps_video_sink.sv ----
`timescale 1ns/10ps
// far-side video receiver: prompt, randomly stalling, or holding off
module tlps_video_sink (
  input  wire logic       clk_i,   // system clock
  input  wire logic [1:0] mode_i,  // 0 prompt, 1 random stall, 2 hold off
  output logic            ready_o  // takes a pixel
);
  int seed = 15637;

  initial ready_o = 1'b0;

  // ready moves just after the edge so the sampling edge never races it
  always @(posedge clk_i) begin
    #1;
    case (mode_i)
      2'h0: ready_o = 1'b1;
      2'h1: ready_o = 1'($random(seed));
      default: ready_o = 1'b0;
    endcase
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench import tlps_pkg::*;;
  logic           sys_clk_i;
  logic           rst_n;
  logic           gain_hi;
  tlps_settings_t boot_set;
  logic           reg_wr;
  logic           reg_rd;
  logic [AW-1:0]  reg_idx;
  logic [DW-1:0]  reg_wdata;
  logic [DW-1:0]  reg_rdata;
  logic           save_we;
  tlps_settings_t save_set;
  logic           pix_valid;
  logic           pix_ready;
  tlps_pix_in_t   pix;
  logic           vid_valid;
  logic           vid_ready;
  tlps_pix_out_t  vid;
  logic [1:0]     sink_mode;
  int             seed = 15637;
  int             num_errors = 0;
  int             checks_done = 0;
  logic [PIX_W:0] exp_q[$];
  logic           m_lin;
  logic           m_step;
  logic [DW-1:0]  m_gain;
  logic [DW-1:0]  m_sofs;
  logic [DW-1:0]  m_emis;
  logic [DW-1:0]  m_refl;

  tlps_scaler u_tlps_scaler (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n),
    .gain_hi_i  (gain_hi),
    .boot_set_i (boot_set),
    .reg_wr_i   (reg_wr),
    .reg_rd_i   (reg_rd),
    .reg_idx_i  (reg_idx),
    .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata),
    .save_we_o  (save_we),
    .save_set_o (save_set),
    .pix_valid_i(pix_valid),
    .pix_ready_o(pix_ready),
    .pix_i      (pix),
    .vid_valid_o(vid_valid),
    .vid_ready_i(vid_ready),
    .vid_o      (vid)
  );

  tlps_video_sink u_tlps_video_sink (
    .clk_i  (sys_clk_i),
    .mode_i (sink_mode),
    .ready_o(vid_ready)
  );

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [DW-1:0] seen, logic [DW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // expected video word from the live settings; clip before the step divide
  function automatic logic [PIX_W:0] expect_pix(logic sof, logic [RAW_W-1:0] s);
    longint c;
    longint t;
    if (!m_lin) return {sof, s[PIX_W-1:0]};
    c = longint'(s) - (((longint'(ONE_Q16) - longint'(m_emis)) * longint'(m_refl)) >>> 16);
    t = ((c - longint'($signed(m_sofs))) * longint'(m_gain)) >>> 16;
    if (t < 0) t = 0;
    if (t > 64'h3FFFF) t = 64'h3FFFF;
    if (!m_step) t = (t * STEP_HI_MK) / STEP_LO_MK; // coarse count is ten fine counts
    if (t > 64'h3FFF) t = 64'h3FFF;
    return {sof, t[PIX_W-1:0]};
  endfunction

  // every register and pixel task starts and ends just after a rising edge
  task automatic wr(logic [AW-1:0] i, logic [DW-1:0] d);
    reg_wr = 1'b1;
    reg_idx = i;
    reg_wdata = d;
    @(posedge sys_clk_i) #1;
    reg_wr = 1'b0;
    @(posedge sys_clk_i) #1;
  endtask

  task automatic rchk(string nm, logic [AW-1:0] i, logic [DW-1:0] e);
    reg_rd = 1'b1;
    reg_idx = i;
    @(posedge sys_clk_i) #1;
    reg_rd = 1'b0;
    chk(nm, reg_rdata, e);
    @(posedge sys_clk_i) #1;
  endtask

  // valid stays up between calls so bursts run at full rate
  task automatic send(logic sof, logic [RAW_W-1:0] s);
    int n;
    n = 0;
    pix_valid = 1'b1;
    pix.sof = sof;
    pix.sig = s;
    while (pix_ready !== 1'b1 && n < 200) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    chk("input accepted", 32'(n < 200), 1);
    exp_q.push_back(expect_pix(sof, s));
    @(posedge sys_clk_i) #1;
  endtask

  task automatic drain();
    int n;
    n = 0;
    pix_valid = 1'b0;
    while (exp_q.size() != 0 && n < 500) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    chk("drained", 32'(exp_q.size()), 0);
  endtask

  // one frame: sof on the first word, a full-scale word second
  task automatic frame(int n);
    for (int k = 0; k < n; k++) begin
      send(k == 0, (k == 1) ? 16'hFFFF : 16'($random(seed)));
    end
    drain();
  endtask

  // output monitor; order and value of each word taken by the sink
  // sampled mid-cycle, where valid and ready stand as the next edge takes them
  always @(negedge sys_clk_i) begin
    if (vid_valid && vid_ready) begin
      if (exp_q.size() == 0) chk("spare video", 1, 0);
      else chk("video", 32'(vid), 32'(exp_q.pop_front()));
    end
  end

  // watchdog sized well above the expected few hundred cycles
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end

  initial begin
    sys_clk_i = 1'b0;
    rst_n = 1'b0;
    gain_hi = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 4'h0;
    reg_wdata = 32'h0;
    pix_valid = 1'b0;
    pix = '0;
    sink_mode = 2'h0;
    boot_set = '0;
    boot_set.emis = ONE_Q16;
    boot_set.pane_tr = ONE_Q16;
    boot_set.air_tr = ONE_Q16;
    boot_set.bank_hi.gain = ONE_Q16;
    boot_set.bank_lo.gain = 32'h0000_8000;
    boot_set.bank_lo.sofs = 32'h0000_0123;
    {m_lin, m_step, m_gain, m_sofs, m_emis, m_refl} = {2'h0, ONE_Q16, 32'h0, ONE_Q16, 32'h0};
    repeat (20) @(posedge sys_clk_i);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    #1;
    rchk("lin_en", IDX_LIN_EN, 32'h0);
    rchk("emis", IDX_EMIS, ONE_Q16);
    rchk("pane_tr", IDX_PANE_TR, ONE_Q16);
    rchk("unmapped", 4'hF, 32'h0);
    // raw mode ignores scene parameters even when they are far from unity
    wr(IDX_EMIS, 32'h0000_8000);
    wr(IDX_REFL, 32'h0000_0200);
    m_refl = 32'h0000_0200;
    sink_mode = 2'h1;
    frame(24);
    // hold the receiver off: two words fit, the third is refused
    sink_mode = 2'h2;
    send(1'b1, 16'h1234);
    send(1'b0, 16'h0ABC);
    chk("full refuses", 32'(pix_ready), 0);
    pix_valid = 1'b0;
    sink_mode = 2'h1;
    drain();
    // linear, fine step, unity scene factors leave the signal untouched
    wr(IDX_EMIS, ONE_Q16);
    wr(IDX_LIN_EN, 32'h1);
    wr(IDX_STEP, 32'h1);
    {m_lin, m_step, m_emis} = {2'h3, ONE_Q16};
    rchk("step", IDX_STEP, 32'h1);
    frame(20);
    wr(IDX_EMIS, 32'h0000_8000);
    m_emis = 32'h0000_8000;
    frame(20);
    wr(IDX_STEP, 32'h0);
    m_step = 1'b0;
    frame(20);
    wr(IDX_SOFS, 32'hFFFF_FF00);
    m_sofs = 32'hFFFF_FF00;
    rchk("signed ofs", IDX_SOFS, 32'hFFFF_FF00);
    frame(20);
    wr(IDX_POS_OFS, 32'hFFFF_FFFF);
    rchk("pos ofs", IDX_POS_OFS, 32'h7FFF_FFFF);
    wr(IDX_EXP, 32'h4148_0000);
    rchk("exponent", IDX_EXP, 32'h4148_0000);
    for (int k = 0; k < 2; k++) begin
      wr(k ? IDX_AIR_T : IDX_PANE_T, 32'h0000_0A00 + 32'(k));
      rchk("scene temp", k ? IDX_AIR_T : IDX_PANE_T, 32'h0000_0A00 + 32'(k));
    end
    // gain flip swaps in the other bank, and back again
    gain_hi = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    rchk("lo sofs", IDX_SOFS, 32'h0000_0123);
    rchk("lo gain", IDX_GAIN, 32'h0000_8000);
    {m_gain, m_sofs} = {32'h0000_8000, 32'h0000_0123};
    frame(16);
    gain_hi = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    {m_gain, m_sofs} = {ONE_Q16, 32'hFFFF_FF00};
    rchk("hi sofs", IDX_SOFS, 32'hFFFF_FF00);
    // save command: one pulse carrying the current settings
    reg_wr = 1'b1;
    reg_idx = IDX_SAVE;
    @(posedge sys_clk_i) #1;
    reg_wr = 1'b0;
    chk("save pulse", 32'(save_we), 1);
    chk("saved ofs", save_set.bank_hi.sofs, 32'hFFFF_FF00);
    chk("saved lin", 32'(save_set.lin_en), 1);
    @(posedge sys_clk_i) #1;
    chk("save ends", 32'(save_we), 0);
    // power cycle with the saved settings as the stored defaults
    boot_set = save_set;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    #1;
    rchk("boot lin", IDX_LIN_EN, 32'h1);
    rchk("boot ofs", IDX_SOFS, 32'hFFFF_FF00);
    rchk("status", IDX_STATUS, 32'h3);
    stop_test();
  end
endmodule
